/* File: maint_msg_pkg.sv */
// Package of field positions, codes and register map for the message codec.
package maint_msg_pkg;

   localparam int ADDR_W = 48;
   localparam int ASID_W = 16;
   localparam int APB_AW = 8;

   // First-part message field positions.
   localparam int LEAF_BIT = 4;
   localparam int STAGE_LO = 2;
   localparam int REGIME_LO = 10;
   localparam int ASID_LO_POS = 16;
   localparam int VMID_POS = 24;
   localparam int ASID_HI_POS = 32;

   typedef enum logic [1:0] {
      STAGE_REV7 = 2'b00,
      STAGE_S1 = 2'b01,
      STAGE_S2 = 2'b10,
      STAGE_RSVD = 2'b11
   } stage_t;

   typedef enum logic [1:0] {
      REGIME_HYP_GUEST = 2'b00,
      REGIME_EL3 = 2'b01,
      REGIME_GUEST = 2'b10,
      REGIME_HYP = 2'b11
   } regime_t;

   localparam logic [4:0] SNOOP_RESP_OK = 5'h00;
   localparam logic [4:0] SNOOP_RESP_UNSUPPORTED = 5'h02;

   // Register byte offsets.
   localparam logic [APB_AW-1:0] REG_CONFIG = 8'h00;
   localparam logic [APB_AW-1:0] REG_ISSUE_ASID = 8'h04;
   localparam logic [APB_AW-1:0] REG_ISSUE_CTRL = 8'h08;
   localparam logic [APB_AW-1:0] REG_ISSUE_ADDR_LO = 8'h0C;
   localparam logic [APB_AW-1:0] REG_ISSUE_ADDR_HI = 8'h10;
   localparam logic [APB_AW-1:0] REG_RX_ASID = 8'h14;
   localparam logic [APB_AW-1:0] REG_RX_STATUS = 8'h18;
   localparam logic [APB_AW-1:0] REG_RX_ADDR_LO = 8'h1C;
   localparam logic [APB_AW-1:0] REG_RX_ADDR_HI = 8'h20;

   // CONFIG fields.
   localparam int CFG_REV8 = 0;
   localparam int CFG_ASID16 = 1;
   localparam int CFG_EL3_64 = 2;
   localparam int CFG_VA_W_LO = 8;
   localparam int CFG_VA_W_W = 6;
   localparam logic [CFG_VA_W_W-1:0] VA_W_RESET = 6'h20;

   // ISSUE_CTRL fields.
   localparam int CTL_LEAF = 0;
   localparam int CTL_STAGE_LO = 1;
   localparam int CTL_REGIME_LO = 3;
   localparam int CTL_EL3_REQ = 5;

   // RX_STATUS fields.
   localparam int ST_LEAF_ONLY = 0;
   localparam int ST_STAGE_LO = 1;
   localparam int ST_REGIME_LO = 3;
   localparam int ST_IPA = 5;
   localparam int ST_UNSUP = 6;
   localparam int ST_VALID = 7;
   localparam int ST_RESP_LO = 8;

endpackage

/* File: maint_msg_encode.sv */
// Issuing path: builds the first-part message address from its fields.
`timescale 1ns/1ps
`default_nettype none
module maint_msg_encode
   import maint_msg_pkg::*;
(
   // Mode.
   input wire logic rev8_maintenance_messaging,
   input wire logic asid16,
   input wire logic el3_is_64bit,
   // Fields.
   input wire logic [maint_msg_pkg::ASID_W-1:0] asid,
   input wire logic [7:0] vmid,
   input wire logic leaf_only,
   input wire logic [1:0] stage,
   input wire logic [1:0] regime,
   input wire logic el3_request,
   // Encoded address.
   output logic [maint_msg_pkg::ADDR_W-1:0] first_addr
);
   always_comb begin
      first_addr = '0;
      first_addr[ASID_LO_POS +: 8] = asid[7:0];
      first_addr[VMID_POS +: 8] = vmid;
      if (rev8_maintenance_messaging) begin
         // An 8-bit issuer keeps the upper byte zero.
         if (asid16)
            first_addr[ASID_HI_POS +: 8] = asid[15:8];
         else
            first_addr[ASID_HI_POS +: 8] = 8'h00;
         first_addr[LEAF_BIT] = leaf_only;
         // The reserved stage code is never sent.
         if (stage != STAGE_RSVD)
            first_addr[STAGE_LO +: 2] = stage;
         if (el3_request && el3_is_64bit)
            first_addr[REGIME_LO +: 2] = REGIME_EL3;
         else if (el3_request)
            first_addr[REGIME_LO +: 2] = REGIME_GUEST;
         else if (regime != REGIME_EL3)
            first_addr[REGIME_LO +: 2] = regime;
         else
            first_addr[REGIME_LO +: 2] = REGIME_GUEST;
      end else begin
         // Older format: only non-EL3 regime codes, no extras.
         if (regime != REGIME_EL3)
            first_addr[REGIME_LO +: 2] = regime;
         else
            first_addr[REGIME_LO +: 2] = REGIME_GUEST;
      end
   end
endmodule
`default_nettype wire

/* File: maint_msg_decode.sv */
// Receiving path: decodes a first-part message into its fields.
`timescale 1ns/1ps
`default_nettype none
module maint_msg_decode
   import maint_msg_pkg::*;
(
   // Mode.
   input wire logic rev8_maintenance_messaging,
   input wire logic asid16,
   // Encoded address.
   input wire logic [maint_msg_pkg::ADDR_W-1:0] first_addr,
   // Fields.
   output logic [maint_msg_pkg::ASID_W-1:0] asid,
   output logic leaf_only,
   output logic [1:0] stage,
   output logic [1:0] regime,
   output logic stage2_ipa,
   output logic unsupported
);
   always_comb begin
      // An 8-bit receiver drops the upper byte; 16-bit takes it as sent.
      if (rev8_maintenance_messaging && asid16)
         asid = {first_addr[ASID_HI_POS +: 8],
                 first_addr[ASID_LO_POS +: 8]};
      else
         asid = {8'h00, first_addr[ASID_LO_POS +: 8]};
      leaf_only = rev8_maintenance_messaging && first_addr[LEAF_BIT];
      stage = first_addr[STAGE_LO +: 2];
      regime = first_addr[REGIME_LO +: 2];
      stage2_ipa = rev8_maintenance_messaging && stage == STAGE_S2;
      unsupported = 1'b0;
      if (!rev8_maintenance_messaging) begin
         if (stage != STAGE_REV7 || regime == REGIME_EL3 ||
               first_addr[LEAF_BIT])
            unsupported = 1'b1;
      end else if (stage == STAGE_RSVD) begin
         unsupported = 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: maint_msg_codec.sv */
// Top of the maintenance message codec with its APB register file.
//
// Operation
// - Version-8 support is a property, false unless software sets it.
// - Version-8 mode adds 16-bit ASID, leaf-only, stage-2 and EL3 regime.
// - Both ASID sizes accepted; message carries no ASID size flag.
// - An 8-bit ASID issuer sends the upper ASID byte as zero.
// - A 16-bit receiver reads 8-bit senders as upper byte zero.
// - An 8-bit receiver ignores the upper ASID byte and matches the lower.
// - Address bit 4 high permits invalidating the leaf entry only.
// - Address bit 4 low requires invalidating all levels.
// - Bits 3:2 select stage: 00 old, 01 stage 1, 10 stage 2, 11 reserved.
// - Stage-2 messages carry the intermediate address in physical layout.
// - Bits 11:10 select regime: all, EL3, guest, hypervisor.
// - EL3 code only for 64-bit EL3; otherwise the guest code.
// - Width handling applies separately to issue and receive paths.
// - Equal widths carry the address directly with no adaptation.
// - Wider physical width sizes the bus; physical operations pass as is.
// - Receiver drops virtual address bits beyond its supported width.
// - Wider virtual width needs a payload wide enough for it.
// - Upper ASID byte travels in first-part bits 39:32.
// - Response is unsupported code if action impossible, else zero.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module maint_msg_codec
   import maint_msg_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic resetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [maint_msg_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Issue path, first part of a message on the read-address channel.
   output logic [maint_msg_pkg::ADDR_W-1:0] issue_addr,
   // Receive path, first part of a message on the snoop-address channel.
   input wire logic snoop_valid,
   input wire logic [maint_msg_pkg::ADDR_W-1:0] snoop_addr,
   output logic snoop_ready,
   output logic snoop_resp_valid,
   output logic [4:0] snoop_resp,
   // Decoded invalidation request.
   output logic inval_valid,
   output logic [maint_msg_pkg::ASID_W-1:0] inval_asid,
   output logic inval_all_levels,
   output logic inval_stage2_ipa
);
   import maint_msg_pkg::*;

   logic rev8_message_support_property;
   logic cfg_asid16;
   logic cfg_el3_64;
   logic [CFG_VA_W_W-1:0] cfg_va_w;
   logic [ASID_W-1:0] iss_asid;
   logic [7:0] iss_vmid;
   logic iss_leaf;
   logic [1:0] iss_stage;
   logic [1:0] iss_regime;
   logic iss_el3;
   logic [ADDR_W-1:0] next_issue_addr;
   logic [ASID_W-1:0] dec_asid;
   logic dec_leaf;
   logic [1:0] dec_stage;
   logic [1:0] dec_regime;
   logic dec_ipa;
   logic dec_unsup;
   logic [ADDR_W-1:0] rx_addr;
   logic [ASID_W-1:0] rx_asid;
   logic rx_leaf;
   logic [1:0] rx_stage;
   logic [1:0] rx_regime;
   logic rx_ipa;
   logic rx_unsup;
   logic rx_valid;
   logic [ADDR_W-1:0] va_mask;
   logic wr_en;
   logic rd_en;
   logic addr_hit;

   // Mask of the address bits that this receiver supports.
   function automatic logic [ADDR_W-1:0] width_mask(
         input logic [CFG_VA_W_W-1:0] w);
      logic [ADDR_W-1:0] m;
      m = '0;
      for (int i = 0; i < ADDR_W; i++) begin
         if (i < int'(w))
            m[i] = 1'b1;
      end
      return m;
   endfunction

   // Snoop response code for a message that was or was not refused.
   function automatic logic [4:0] resp_code(input logic unsup);
      if (unsup)
         return SNOOP_RESP_UNSUPPORTED;
      else
         return SNOOP_RESP_OK;
   endfunction

   // Writes land at the access edge; reads load in the setup cycle.
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !pwrite;
   // Zero wait states: every access phase ends at its first edge.
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addr_hit;
   // Every snoop message is taken in the cycle in which it is offered.
   assign snoop_ready = 1'b1;
   assign va_mask = width_mask(cfg_va_w);

   // Offsets that hold a register; any other answers with a slave error.
   always_comb begin
      unique case (paddr)
         REG_CONFIG, REG_ISSUE_ASID, REG_ISSUE_CTRL, REG_ISSUE_ADDR_LO,
         REG_ISSUE_ADDR_HI, REG_RX_ASID, REG_RX_STATUS, REG_RX_ADDR_LO,
         REG_RX_ADDR_HI: addr_hit = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   end

   // Configuration: version-8 support is off until software enables it.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rev8_message_support_property <= 1'b0;
         cfg_asid16 <= 1'b0;
         cfg_el3_64 <= 1'b0;
         cfg_va_w <= VA_W_RESET;
      end else if (wr_en && paddr == REG_CONFIG) begin
         rev8_message_support_property <= pwdata[CFG_REV8];
         cfg_asid16 <= pwdata[CFG_ASID16];
         cfg_el3_64 <= pwdata[CFG_EL3_64];
         cfg_va_w <= pwdata[CFG_VA_W_LO +: CFG_VA_W_W];
      end
   end

   // Issue ASID and VMID.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         iss_asid <= '0;
         iss_vmid <= '0;
      end else if (wr_en && paddr == REG_ISSUE_ASID) begin
         iss_asid <= pwdata[ASID_W-1:0];
         iss_vmid <= pwdata[ASID_W +: 8];
      end
   end

   // Issue control fields.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         iss_leaf <= 1'b0;
         iss_stage <= STAGE_REV7;
         iss_regime <= REGIME_HYP_GUEST;
         iss_el3 <= 1'b0;
      end else if (wr_en && paddr == REG_ISSUE_CTRL) begin
         iss_leaf <= pwdata[CTL_LEAF];
         iss_stage <= pwdata[CTL_STAGE_LO +: 2];
         iss_regime <= pwdata[CTL_REGIME_LO +: 2];
         iss_el3 <= pwdata[CTL_EL3_REQ];
      end
   end

   maint_msg_encode u_encode (
      .rev8_maintenance_messaging(rev8_message_support_property),
      .asid16(cfg_asid16),
      .el3_is_64bit(cfg_el3_64),
      .asid(iss_asid),
      .vmid(iss_vmid),
      .leaf_only(iss_leaf),
      .stage(iss_stage),
      .regime(iss_regime),
      .el3_request(iss_el3),
      .first_addr(next_issue_addr)
   );

   // The issue address drives the full bus width directly.
   always_ff @(posedge clk_sys) begin
      if (!resetn)
         issue_addr <= '0;
      else
         issue_addr <= next_issue_addr;
   end

   // Receive decode; its outputs count only while snoop_valid is high.
   maint_msg_decode u_decode (
      .rev8_maintenance_messaging(rev8_message_support_property),
      .asid16(cfg_asid16),
      .first_addr(snoop_addr),
      .asid(dec_asid),
      .leaf_only(dec_leaf),
      .stage(dec_stage),
      .regime(dec_regime),
      .stage2_ipa(dec_ipa),
      .unsupported(dec_unsup)
   );

   // Captured receive message; unsupported bits are discarded.
   // A refused message is still recorded so software can see why.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         rx_addr <= '0;
         rx_asid <= '0;
         rx_leaf <= 1'b0;
         rx_stage <= STAGE_REV7;
         rx_regime <= REGIME_HYP_GUEST;
         rx_ipa <= 1'b0;
         rx_unsup <= 1'b0;
         rx_valid <= 1'b0;
      end else if (snoop_valid) begin
         // Stage-2 carries an intermediate address kept at full width.
         if (dec_ipa)
            rx_addr <= snoop_addr;
         else
            rx_addr <= snoop_addr & va_mask;
         rx_asid <= dec_asid;
         rx_leaf <= dec_leaf;
         rx_stage <= dec_stage;
         rx_regime <= dec_regime;
         rx_ipa <= dec_ipa;
         rx_unsup <= dec_unsup;
         rx_valid <= 1'b1;
      end
   end

   // Snoop response, one cycle after the message.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         snoop_resp_valid <= 1'b0;
         snoop_resp <= SNOOP_RESP_OK;
      end else begin
         snoop_resp_valid <= snoop_valid;
         if (snoop_valid)
            snoop_resp <= resp_code(dec_unsup);
      end
   end

   // Invalidation request, one cycle after a supported message.
   // A refused message must not start even a partial invalidation.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         inval_valid <= 1'b0;
         inval_asid <= '0;
         inval_all_levels <= 1'b1;
         inval_stage2_ipa <= 1'b0;
      end else begin
         inval_valid <= snoop_valid && !dec_unsup;
         if (snoop_valid) begin
            inval_asid <= dec_asid;
            inval_all_levels <= !dec_leaf;
            inval_stage2_ipa <= dec_ipa;
         end
      end
   end

   // Read data register. It loads in the setup cycle, so the data stand
   // through the whole access phase and until the next read setup.
   // Fields that a register does not use read as zero.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en && !penable) begin
         prdata <= 32'h0000_0000;
         unique case (paddr)
            REG_CONFIG: begin
               prdata[CFG_REV8] <= rev8_message_support_property;
               prdata[CFG_ASID16] <= cfg_asid16;
               prdata[CFG_EL3_64] <= cfg_el3_64;
               prdata[CFG_VA_W_LO +: CFG_VA_W_W] <= cfg_va_w;
            end
            REG_ISSUE_ASID: begin
               prdata[ASID_W-1:0] <= iss_asid;
               prdata[ASID_W +: 8] <= iss_vmid;
            end
            REG_ISSUE_CTRL: begin
               prdata[CTL_LEAF] <= iss_leaf;
               prdata[CTL_STAGE_LO +: 2] <= iss_stage;
               prdata[CTL_REGIME_LO +: 2] <= iss_regime;
               prdata[CTL_EL3_REQ] <= iss_el3;
            end
            REG_ISSUE_ADDR_LO: prdata <= issue_addr[31:0];
            REG_ISSUE_ADDR_HI: prdata[ADDR_W-33:0] <= issue_addr[ADDR_W-1:32];
            REG_RX_ASID: prdata[ASID_W-1:0] <= rx_asid;
            REG_RX_STATUS: begin
               prdata[ST_LEAF_ONLY] <= rx_leaf;
               prdata[ST_STAGE_LO +: 2] <= rx_stage;
               prdata[ST_REGIME_LO +: 2] <= rx_regime;
               prdata[ST_IPA] <= rx_ipa;
               prdata[ST_UNSUP] <= rx_unsup;
               prdata[ST_VALID] <= rx_valid;
               prdata[ST_RESP_LO +: 5] <= resp_code(rx_unsup);
            end
            REG_RX_ADDR_LO: prdata <= rx_addr[31:0];
            REG_RX_ADDR_HI: prdata[ADDR_W-33:0] <= rx_addr[ADDR_W-1:32];
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule
`default_nettype wire

/* File: codec_properties.sv */
// Checker of the snoop receive path of the message codec.
`timescale 1ns/1ps
`default_nettype none
module codec_checker
   import maint_msg_pkg::*;
(
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic resetn,
   // Snoop channel and decoded request.
   input wire logic snoop_valid,
   input wire logic [maint_msg_pkg::ADDR_W-1:0] snoop_addr,
   input wire logic snoop_resp_valid,
   input wire logic [4:0] snoop_resp,
   input wire logic inval_valid,
   input wire logic [maint_msg_pkg::ASID_W-1:0] inval_asid,
   input wire logic inval_all_levels,
   input wire logic inval_stage2_ipa
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // A message matching the condition that was then performed.
   sequence s_done(c);
      snoop_valid && c ##1 inval_valid;
   endsequence
   chk_resp_follows: assert property (snoop_valid |=> snoop_resp_valid)
      else $error("snoop response missing");
   chk_resp_cause: assert property (snoop_resp_valid |-> $past(snoop_valid))
      else $error("snoop response without message");
   chk_resp_code: assert property (snoop_resp_valid |->
      snoop_resp == SNOOP_RESP_OK || snoop_resp == SNOOP_RESP_UNSUPPORTED)
      else $error("bad snoop response code");
   chk_inval_ok: assert property (inval_valid |->
      snoop_resp_valid && snoop_resp == SNOOP_RESP_OK)
      else $error("invalidation on refused message");
   chk_rsvd_stage: assert property (snoop_valid &&
      snoop_addr[3:2] == 2'b11 |=>
      snoop_resp == SNOOP_RESP_UNSUPPORTED && !inval_valid)
      else $error("reserved stage accepted");
   chk_all_levels: assert property (s_done(!snoop_addr[LEAF_BIT]) |->
      inval_all_levels)
      else $error("all levels not requested");
   chk_stage2_ipa: assert property (s_done(snoop_addr[3:2] == 2'b10) |->
      inval_stage2_ipa)
      else $error("stage 2 not decoded as ipa");
   chk_asid_low: assert property (s_done(1'b1) |->
      inval_asid[7:0] == $past(snoop_addr[23:16]))
      else $error("lower asid byte wrong");
endmodule
bind maint_msg_codec codec_checker chk (.clk_sys, .resetn, .snoop_valid,
   .snoop_addr, .snoop_resp_valid, .snoop_resp, .inval_valid, .inval_asid,
   .inval_all_levels, .inval_stage2_ipa);
`default_nettype wire

/* File: icn_model.sv */
// Interconnect model that sends first-part messages on the snoop channel.
`timescale 1ns/1ps
`default_nettype none
module icn_model
   import maint_msg_pkg::*;
(
   // Clock.
   input wire logic clk_sys,
   // Snoop address channel.
   output logic snoop_valid,
   output logic [maint_msg_pkg::ADDR_W-1:0] snoop_addr,
   input wire logic snoop_ready
);
   logic expired;
   initial begin
      snoop_valid = 1'b0;
      snoop_addr = '0;
      expired = 1'b0;
   end
   // The caller places stage, regime and upper ASID in their fields.
   task automatic send(input logic [ADDR_W-1:0] a);
      @(posedge clk_sys);
      snoop_valid <= 1'b1;
      snoop_addr <= a;
      @(posedge clk_sys);
      for (int n = 0; n < 8 && snoop_ready !== 1'b1; n++) begin
         @(posedge clk_sys);
      end
      if (snoop_ready !== 1'b1)
         expired = 1'b1;
      snoop_valid <= 1'b0;
      // A stale address must not look valid, so show its inverse.
      snoop_addr <= ~a;
   endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking testbench of the maintenance message codec.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import maint_msg_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [APB_AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, snoop_valid, snoop_ready, snoop_resp_valid, err;
   logic inval_valid, inval_all_levels, inval_stage2_ipa;
   logic [ADDR_W-1:0] issue_addr, snoop_addr, e;
   logic [4:0] snoop_resp;
   logic [ASID_W-1:0] inval_asid;
   int mismatches = 0;
   int n_compared = 0;
   always #5 clk_sys = ~clk_sys;
   maint_msg_codec dut (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .issue_addr, .snoop_valid,
      .snoop_addr, .snoop_ready, .snoop_resp_valid, .snoop_resp,
      .inval_valid, .inval_asid, .inval_all_levels, .inval_stage2_ipa);
   icn_model icn (.clk_sys, .snoop_valid, .snoop_addr, .snoop_ready);
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      for (n = 0; n < 8 && pready !== 1'b1; n++) begin
         @(posedge clk_sys);
      end
      if (n == 8) begin
         mismatches++;
         complete_run();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // First-part message address built from its fields.
   function automatic logic [47:0] first(input logic [7:0] hi, vm, lo,
      input logic [1:0] rg, st, input logic lf);
      return {8'h00, hi, vm, lo, 4'h0, rg, 5'h00, lf, st, 2'b00};
   endfunction
   task automatic issue(input logic [31:0] cfg, ctl);
      apb(1'b1, REG_CONFIG, cfg);
      apb(1'b1, REG_ISSUE_CTRL, ctl);
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   task automatic rx(input logic [47:0] a, input logic [4:0] r,
      input logic [15:0] s, input logic lvl, ipa);
      icn.send(a);
      if (icn.expired) begin
         mismatches++;
         complete_run();
      end
      #1;
      check(snoop_resp_valid, 1'b1);
      check(snoop_resp, r);
      check(inval_valid, r == SNOOP_RESP_OK);
      if (r == SNOOP_RESP_OK) begin
         check(inval_asid, s);
         check(inval_all_levels, lvl);
         check(inval_stage2_ipa, ipa);
      end
   endtask
   task automatic t_reset();
      #1;
      check(issue_addr, 48'h0);
      apb(1'b0, REG_CONFIG, 32'h0);
      check(rd, 32'h0000_2000);
      apb(1'b0, 8'h40, 32'h0);
      check({err, rd}, 33'h1_0000_0000);
   endtask
   task automatic t_issue();
      apb(1'b1, REG_ISSUE_ASID, 32'h0056_AB12);
      issue(32'h0000_2000, 32'h0000_000B);
      check(issue_addr, first(8'h00, 8'h56, 8'h12, 2'b10, 2'b00, 1'b0));
      issue(32'h0000_2007, 32'h0000_0025);
      e = first(8'hAB, 8'h56, 8'h12, 2'b01, 2'b10, 1'b1);
      check(issue_addr, e);
      apb(1'b0, REG_ISSUE_ADDR_HI, 32'h0);
      check(rd, {16'h0, e[47:32]});
      issue(32'h0000_2003, 32'h0000_0025);
      check(issue_addr, first(8'hAB, 8'h56, 8'h12, 2'b10, 2'b10, 1'b1));
      issue(32'h0000_2001, 32'h0000_0007);
      e = first(8'h00, 8'h56, 8'h12, 2'b00, 2'b00, 1'b1);
      check(issue_addr, e);
      apb(1'b0, REG_ISSUE_ADDR_LO, 32'h0);
      check(rd, e[31:0]);
   endtask
   task automatic t_receive();
      apb(1'b1, REG_CONFIG, 32'h0000_2000);
      rx(first(8'h0, 8'h0, 8'h34, 2'b00, 2'b00, 1'b0), 5'h00, 16'h34, 1, 0);
      rx(first(8'h0, 8'h0, 8'h34, 2'b00, 2'b01, 1'b0), 5'h02, 16'h0, 0, 0);
      apb(1'b1, REG_CONFIG, 32'h0000_2003);
      rx(first(8'hCD, 8'h0, 8'h34, 2'b00, 2'b10, 1'b1), 5'h00, 16'hCD34, 0, 1);
      rx(first(8'h0, 8'h0, 8'h34, 2'b00, 2'b11, 1'b0), 5'h02, 16'h0, 0, 0);
      for (int g = 0; g < 4; g++) begin
         rx(first(8'h0, 8'h0, 8'h34, g[1:0], 2'b01, 1'b0), 5'h00, 16'h34, 1, 0);
         apb(1'b0, REG_RX_STATUS, 32'h0);
         check(rd[4:3], g[1:0]);
      end
      apb(1'b1, REG_CONFIG, 32'h0000_1401);
      rx(first(8'hCD, 8'h0, 8'h34, 2'b11, 2'b01, 1'b0), 5'h00, 16'h34, 1, 0);
      apb(1'b0, REG_RX_ADDR_LO, 32'h0);
      check(rd, 32'h0004_0C04);
      rx(first(8'h0, 8'h0, 8'h34, 2'b00, 2'b10, 1'b0), 5'h00, 16'h34, 1, 1);
      apb(1'b0, REG_RX_ADDR_LO, 32'h0);
      check(rd, 32'h0034_0008);
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      t_reset();
      t_issue();
      t_receive();
      complete_run();
   end
endmodule
`default_nettype wire
